/* File: hdl/sld_ctrl.sv */
// segment display driver control, reset and waveform timing
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl
  import sld_pkg::*;
#(
  parameter int unsigned SEG_N   = 21,
  parameter int unsigned HOLD_CYC = RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_B_I,
  // control register image
  input  wire logic             CTL_WE_I,
  input  wire logic [7:0]       CTL_WDATA_I,
  output var  logic [7:0]       CTL_RDATA_O,
  // power state and reset causes
  input  wire logic             SLEEP_I,
  input  wire logic             MCU_RST_I,
  input  wire logic             WDT_RST_I,
  input  wire logic             SLOW_CLK_I,
  // display memory write
  input  wire logic             MEM_WE_I,
  input  wire logic [4:0]       MEM_ADDR_I,
  input  wire logic [2:0]       MEM_WDATA_I,
  // panel lines, level 0 low 1 mid 2 high; oe low means driven
  output var  logic [2:0][1:0]  COM_LVL_O,
  output var  logic [2:0]       COM_OE_B_O,
  output var  logic [SEG_N-1:0][1:0] SEG_LVL_O,
  output var  logic [SEG_N-1:0] SEG_OE_B_O,
  output var  logic             SEG_X_LVL_HI_O,
  output var  logic             PUMP_ON_O,
  output var  logic             DRV_RST_O
);
  // elaboration checks: scan counter is five bits, hold counter sixteen
  if (SEG_N < 1 || SEG_N > 31) begin : g_seg_chk
    $error("segment count out of range");
  end
  if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin : g_hold_chk
    $error("hold count out of range");
  end

  // ****************************************
  // control register
  // ****************************************
  logic [7:0] ctl_q, ctl_d;
  logic       on_w, duty_half_w, type_b_w;
  always_comb begin
    ctl_d = ctl_q;
    if (CTL_WE_I) begin
      ctl_d = CTL_WDATA_I & CTL_WR_MASK;  // unimplemented bits read zero
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) ctl_q <= CTL_RESET_VAL;
    else ctl_q <= ctl_d;
  end
  assign on_w        = ctl_q[CTL_ON_BIT];
  assign duty_half_w = ctl_q[CTL_DUTY_BIT];
  assign type_b_w    = ctl_q[CTL_TYPE_BIT];

  // ****************************************
  // slow clock pin sync, three stages
  // ****************************************
  logic [2:0] sync_q, sync_d;
  logic       slow_lvl_q, slow_lvl_d;
  logic       slow_rise_w;
  always_comb begin
    sync_d     = {sync_q[1:0], SLOW_CLK_I};
    slow_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : slow_lvl_q;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      sync_q     <= 3'h0;
      slow_lvl_q <= 1'b0;
    end else begin
      sync_q     <= sync_d;
      slow_lvl_q <= slow_lvl_d;
    end
  end
  assign slow_rise_w = slow_lvl_d & ~slow_lvl_q;

  // ****************************************
  // reset and state: mcu reset floats while the display is on, otherwise blank or drive
  // ****************************************
  logic       mcu_rst_w, drv_rst_w;
  logic [15:0] hold_q, hold_d;
  sld_state_t st_q, st_d;
  // watchdog timeout while sleeping does not count as mcu reset
  assign mcu_rst_w = MCU_RST_I & ~(WDT_RST_I & SLEEP_I);
  assign drv_rst_w = ~on_w | SLEEP_I;
  always_comb begin
    hold_d = (hold_q != 16'h0000) ? hold_q - 16'h0001 : hold_q;
    if (mcu_rst_w) hold_d = 16'(HOLD_CYC);
    st_d = st_q;
    case (st_q)
      SLD_FLOAT: if (hold_d == 16'h0000) st_d = SLD_BLANK;
      SLD_BLANK: if (!drv_rst_w) st_d = SLD_DRIVE;
      SLD_DRIVE: if (drv_rst_w) st_d = SLD_BLANK;
      default:   st_d = SLD_FLOAT;
    endcase
    if (mcu_rst_w && on_w) st_d = SLD_FLOAT;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      hold_q <= 16'h0000;
      st_q   <= SLD_BLANK;
    end else begin
      hold_q <= hold_d;
      st_q   <= st_d;
    end
  end

  // ****************************************
  // frame timing: divide by eight, slot and phase
  // ****************************************
  logic [2:0] div_q, div_d;
  logic [1:0] slot_q, slot_d;
  logic       ph_q, ph_d, fr_q, fr_d;
  logic       tick_w, live_w;
  logic [1:0] ncom_w;
  assign live_w = (st_q == SLD_DRIVE);
  assign ncom_w = duty_half_w ? 2'(COM_HALF) : 2'(COM_MAX);
  assign tick_w = slow_rise_w && (div_q == 3'(SLOW_DIV - 1));
  always_comb begin
    div_d = div_q; slot_d = slot_q; ph_d = ph_q; fr_d = fr_q;
    if (!live_w) begin
      div_d = 3'h0; slot_d = 2'h0; ph_d = 1'b0; fr_d = 1'b0;
    end else if (CTL_WE_I && (ctl_d[CTL_DUTY_BIT] != duty_half_w)) begin
      // duty change restarts the frame so the slot never sits beyond the commons
      div_d = 3'h0; slot_d = 2'h0; ph_d = 1'b0; fr_d = 1'b0;
    end else if (slow_rise_w) begin
      div_d = div_q + 3'h1;
      if (tick_w) begin
        // type A flips polarity inside each slot, type B once per frame
        if (!type_b_w && !ph_q) ph_d = 1'b1;
        else begin
          ph_d = 1'b0;
          if (slot_q >= ncom_w - 2'h1) begin
            slot_d = 2'h0;
            fr_d   = ~fr_q;
          end else slot_d = slot_q + 2'h1;
        end
      end
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      div_q <= 3'h0; slot_q <= 2'h0; ph_q <= 1'b0; fr_q <= 1'b0;
    end else begin
      div_q <= div_d; slot_q <= slot_d; ph_q <= ph_d; fr_q <= fr_d;
    end
  end

  // ****************************************
  // display memory: one segment column per address, bit per common
  // ****************************************
  logic [4:0] scan_q, scan_d;
  logic [2:0] pix_w;
  logic [SEG_N-1:0][2:0] col_q, col_d;
  always_comb begin
    scan_d = (32'(scan_q) >= SEG_N) ? 5'h00 : scan_q + 5'h01;
    col_d  = col_q;
    if (32'(scan_q) >= 1 && 32'(scan_q) <= SEG_N) col_d[scan_q - 5'h01] = pix_w;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      scan_q <= 5'h00; col_q <= '0;
    end else begin
      scan_q <= scan_d; col_q <= col_d;
    end
  end
  sld_seg_mem #(.DEPTH(SEG_N + 1), .AW(5)) u_mem (
    .clk_i   (CLK_SYS_I),
    .we_i    (MEM_WE_I),
    .waddr_i (MEM_ADDR_I),
    .wdata_i (MEM_WDATA_I),
    .raddr_i (scan_q),
    .rdata_o (pix_w)
  );

  // ****************************************
  // line levels: mid for unselected, polarity swaps keep DC at zero
  // ****************************************
  logic       pol_w;
  logic       drive_nx_w;
  assign pol_w = type_b_w ? fr_q : ph_q;
  // levels follow the next state, so blanking lands together with the enables
  assign drive_nx_w = (st_d == SLD_DRIVE);
  function automatic logic [1:0] lvl(input logic hi);
    return hi ? 2'h2 : 2'h0;
  endfunction
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      COM_LVL_O <= '0; COM_OE_B_O <= '0; SEG_LVL_O <= '0; SEG_OE_B_O <= '0;
      SEG_X_LVL_HI_O <= 1'b0; PUMP_ON_O <= 1'b0; DRV_RST_O <= 1'b1;
    end else begin
      COM_OE_B_O <= {3{st_d == SLD_FLOAT}};
      SEG_OE_B_O <= {SEG_N{st_d == SLD_FLOAT}};
      for (int c = 0; c < COM_MAX; c++) begin
        if (!drive_nx_w) COM_LVL_O[c] <= 2'h0;
        else if (32'(c) >= 32'(ncom_w)) COM_LVL_O[c] <= lvl(~pol_w ^ col_q[0][c]);
        else if (slot_q == 2'(c)) COM_LVL_O[c] <= lvl(pol_w);
        else COM_LVL_O[c] <= 2'h1;
      end
      for (int s = 0; s < SEG_N; s++) begin
        SEG_LVL_O[s] <= drive_nx_w ? lvl(~pol_w ^ ~col_q[s][slot_q]) : 2'h0;
      end
      SEG_X_LVL_HI_O <= drive_nx_w & pol_w;
      PUMP_ON_O      <= ctl_q[CTL_PUMP_BIT];
      DRV_RST_O      <= drv_rst_w | mcu_rst_w;
    end
    CTL_RDATA_O <= RST_B_I ? ctl_d : CTL_RESET_VAL;
  end

  // ****************************************
  // checks
  // ****************************************
  sequence rst_cause_s; mcu_rst_w && on_w; endsequence
  blank_low_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (drv_rst_w && !mcu_rst_w && st_q != SLD_FLOAT) |=> COM_LVL_O == '0)
    else $error("blank lines not low");
  float_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    rst_cause_s |=> COM_OE_B_O == 3'h7)
    else $error("lines not floated on reset");
  drv_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (!on_w || SLEEP_I) |=> DRV_RST_O)
    else $error("driver not reset");
  wdt_excl_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (WDT_RST_I && SLEEP_I && st_q != SLD_FLOAT) |=> st_q != SLD_FLOAT)
    else $error("watchdog floated lines");
  slot_order_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (live_w && $changed(slot_q) && slot_q != 2'h0) |-> slot_q == $past(slot_q) + 2'h1)
    else $error("slot order broken");
  slot_range_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    slot_q < ncom_w || !live_w)
    else $error("slot beyond duty");
  power_on_a: assert property (@(posedge CLK_SYS_I)
    !RST_B_I |=> !on_w)
    else $error("enable not cleared");
  clear_stop_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (live_w && CTL_WE_I && !CTL_WDATA_I[CTL_ON_BIT]) |=> ##1 !live_w)
    else $error("clear did not stop");
endmodule // sld_ctrl
`default_nettype wire

/* File: hdl/sld_pkg.sv */
// package of constants for the segment display driver control block
`default_nettype none
package sld_pkg;
  // ****************************************
  // control bit positions of the display control register image
  // ****************************************
  localparam int unsigned CTL_ON_BIT    = 0;
  localparam int unsigned CTL_DUTY_BIT  = 1;
  localparam int unsigned CTL_PUMP_BIT  = 2;
  localparam int unsigned CTL_TYPE_BIT  = 7;
  localparam logic [7:0]  CTL_RESET_VAL = 8'h00;
  localparam logic [7:0]  CTL_WR_MASK   = 8'h87;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned SLOW_DIV      = 8;
  localparam int unsigned COM_MAX       = 3;
  localparam int unsigned COM_HALF      = 2;
  localparam int unsigned SYS_CLK_HZ    = 100_000_000;
  localparam int unsigned RST_DELAY_NS  = 1000;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned RST_HOLD_CYC  = ((RST_DELAY_NS + SETTLE_NS) * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  // ****************************************
  // driver state
  // ****************************************
  typedef enum logic [1:0] {
    SLD_FLOAT = 2'b00,
    SLD_BLANK = 2'b01,
    SLD_DRIVE = 2'b11
  } sld_state_t;
endpackage
`default_nettype wire

/* File: hdl/sld_seg_mem.sv */
// small display memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module sld_seg_mem #(
  parameter int unsigned DEPTH = 22,
  parameter int unsigned AW    = 5
) (
  // clock
  input  wire logic          clk_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [2:0]    wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output var  logic [2:0]    rdata_o
);
  logic [2:0] mem_q [DEPTH];
  // elaboration check: every word must be reachable by the address
  if (DEPTH > (1 << AW)) begin : g_depth_chk
    $error("depth too big for address");
  end
  // ****************************************
  // storage, no reset: software fills it after power-up
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (we_i && (32'(waddr_i) < DEPTH)) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= (32'(raddr_i) < DEPTH) ? mem_q[raddr_i] : 3'h0;
  end
endmodule // sld_seg_mem
`default_nettype wire

/* File: tb/sld_panel_model.sv */
// passive glass panel model integrating one pixel's drive voltage
`timescale 1ns/1ps
`default_nettype none
module sld_panel_model (
  // clock and clear
  input  wire logic            clk_i,
  input  wire logic            clr_i,
  // first common and first segment line of the panel
  input  wire logic [1:0]      com_lvl_i,
  input  wire logic            com_oe_b_i,
  input  wire logic [1:0]      line_lvl_i,
  input  wire logic            line_oe_b_i,
  // running sum of common minus segment level
  output var  int              dc_acc_o
);
  // ****************************************
  // pixel charge integrator
  // ****************************************
  // only driven samples count: a floating line puts no charge on the pixel
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      dc_acc_o <= 0;
    end else if (!com_oe_b_i && !line_oe_b_i) begin
      dc_acc_o <= dc_acc_o + int'(com_lvl_i) - int'(line_lvl_i);
    end
  end
endmodule // sld_panel_model
`default_nettype wire

/* File: tb/sld_ctrl_tb.sv */
// self-checking testbench for the display driver control block
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl_tb;
  import sld_pkg::*;
  localparam int HOLD = 4;
  logic CLK_SYS_I = 0, RST_B_I = 0, CTL_WE_I = 0, SLEEP_I = 0, MCU_RST_I = 0, WDT_RST_I = 0, SLOW_CLK_I = 0;
  logic MEM_WE_I = 0;
  logic [4:0] MEM_ADDR_I = 5'h0;
  logic [2:0] MEM_WDATA_I = 3'h0;
  logic [7:0] CTL_WDATA_I = 8'h00, CTL_RDATA_O;
  logic [2:0][1:0] COM_LVL_O;
  logic [2:0] COM_OE_B_O;
  logic [20:0][1:0] SEG_LVL_O;
  logic [20:0] SEG_OE_B_O;
  logic SEG_X_LVL_HI_O, PUMP_ON_O, DRV_RST_O, clr;
  int dc_acc, failures = 0, samples_checked = 0, ca, cb, ch;
  // ****************************************
  // clocks and instances
  // ****************************************
  always #5 CLK_SYS_I = ~CLK_SYS_I;
  // slow clock kept at four system cycles so a slot lands on a 32-cycle grid
  always #20 SLOW_CLK_I = ~SLOW_CLK_I;
  sld_ctrl #(.SEG_N(21), .HOLD_CYC(HOLD)) sld_ctrl_i (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
    .CTL_WE_I(CTL_WE_I), .CTL_WDATA_I(CTL_WDATA_I), .CTL_RDATA_O(CTL_RDATA_O), .SLEEP_I(SLEEP_I),
    .MCU_RST_I(MCU_RST_I), .WDT_RST_I(WDT_RST_I), .SLOW_CLK_I(SLOW_CLK_I), .MEM_WE_I(MEM_WE_I),
    .MEM_ADDR_I(MEM_ADDR_I), .MEM_WDATA_I(MEM_WDATA_I), .COM_LVL_O(COM_LVL_O), .COM_OE_B_O(COM_OE_B_O),
    .SEG_LVL_O(SEG_LVL_O), .SEG_OE_B_O(SEG_OE_B_O), .SEG_X_LVL_HI_O(SEG_X_LVL_HI_O),
    .PUMP_ON_O(PUMP_ON_O), .DRV_RST_O(DRV_RST_O));
  sld_panel_model sld_panel_model_i (.clk_i(CLK_SYS_I), .clr_i(clr), .com_lvl_i(COM_LVL_O[0]),
    .com_oe_b_i(COM_OE_B_O[0]), .line_lvl_i(SEG_LVL_O[0]), .line_oe_b_i(SEG_OE_B_O[0]), .dc_acc_o(dc_acc));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS_I);
  endtask
  // one-cycle write strobe, outputs settle one cycle after readback
  task automatic wr(input logic [7:0] d);
    CTL_WE_I = 1;
    CTL_WDATA_I = d;
    cyc(1);
    CTL_WE_I = 0;
    cyc(3);
  endtask
  task automatic blank();
    chk("drv_rst", 8'h01, {7'h0, DRV_RST_O});
    chk("com_lvl", 8'h00, {2'b00, COM_LVL_O});
    chk("com_oe_b", 8'h00, {5'h0, COM_OE_B_O});
    chk("segment_lvl", 8'h00, {7'h0, |SEG_LVL_O});
    chk("segment_oe_b", 8'h00, {7'h0, |SEG_OE_B_O});
  endtask
  // follows the selected common: exactly one away from mid level, ascending;
  // chg counts polarity flips of the phase indicator, a measure of frequency
  task automatic watch(input int n, input int len, output int chg);
    int last_t, sel, prev_sel, nm;
    logic [5:0] prev;
    logic prev_x;
    prev = COM_LVL_O;
    prev_x = SEG_X_LVL_HI_O;
    prev_sel = -1;
    last_t = -1;
    chg = 0;
    for (int t = 0; t < len; t++) begin
      cyc(1);
      if (SEG_X_LVL_HI_O !== prev_x) begin
        chg++;
        prev_x = SEG_X_LVL_HI_O;
      end
      sel = -1;
      nm = 0;
      for (int k = 0; k < n; k++) if (COM_LVL_O[k] !== 2'd1) begin
        sel = k;
        nm++;
      end
      if (COM_LVL_O !== prev) begin
        if (last_t >= 0) chk("step_gap", 8'h00, 8'((t - last_t) % 32));
        chk("selected_count", 8'h01, 8'(nm));
        if (n < 3) chk("com2_segment", 8'h00, {7'h0, COM_LVL_O[2] == 2'd1});
        if (prev_sel >= 0 && sel != prev_sel) chk("com_order", 8'((prev_sel + 1) % n), 8'(sel));
        last_t = t;
        prev_sel = sel;
        prev = COM_LVL_O;
      end
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clr = 1;
    cyc(12);
    RST_B_I = 1;
    cyc(1);
    chk("ctl_after_reset", 8'h00, CTL_RDATA_O);
    blank();
    // known pattern into every display memory location
    for (int a = 0; a < 22; a++) begin
      MEM_WE_I = 1;
      MEM_ADDR_I = 5'(a);
      MEM_WDATA_I = 3'(a);
      cyc(1);
    end
    MEM_WE_I = 0;
    wr(8'hFF);
    chk("ctl_mask", 8'h87, CTL_RDATA_O);
    wr(8'h05);
    chk("drv_rst_on", 8'h00, {7'h0, DRV_RST_O});
    chk("pump", 8'h01, {7'h0, PUMP_ON_O});
    clr = 0;
    watch(3, 1536, ca);
    chk("dc_bounded", 8'h01, {7'h0, (dc_acc < 800 && dc_acc > -800)});
    chk("com_oe_driven", 8'h00, {5'h0, COM_OE_B_O});
    wr(8'h85);
    watch(3, 1536, cb);
    chk("type_b_slower", 8'h01, {7'h0, cb < ca && cb > 0});
    wr(8'h87);
    watch(2, 1536, ch);
    chk("half_duty_runs", 8'h01, {7'h0, ch >= 2});
    wr(8'h04);
    chk("ctl_off", 8'h04, CTL_RDATA_O);
    blank();
    wr(8'h05);
    SLEEP_I = 1;
    cyc(3);
    blank();
    // watchdog reset while asleep must blank, not float
    MCU_RST_I = 1;
    WDT_RST_I = 1;
    cyc(4);
    chk("wdt_no_float", 8'h00, {5'h0, COM_OE_B_O});
    MCU_RST_I = 0;
    WDT_RST_I = 0;
    SLEEP_I = 0;
    cyc(3);
    chk("awake", 8'h00, {7'h0, DRV_RST_O});
    MCU_RST_I = 1;
    cyc(3);
    chk("mcu_rst_com", 8'h07, {5'h0, COM_OE_B_O});
    chk("mcu_rst_segment", 8'h01, {7'h0, &SEG_OE_B_O});
    MCU_RST_I = 0;
    cyc(2);
    chk("hold_float", 8'h07, {5'h0, COM_OE_B_O});
    cyc(HOLD + 4);
    chk("float_ends", 8'h00, {5'h0, COM_OE_B_O});
    end_of_test();
  end
endmodule // sld_ctrl_tb
`default_nettype wire
